// *** rtl/flash_seq_pkg.sv ***
package flash_seq_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	// device register offsets
	localparam logic [19:0] OFS_CTRL_PRI = 20'h00220;
	localparam logic [19:0] OFS_CTRL_SEC = 20'h00221;
	localparam logic [19:0] OFS_CTRL_THIRD = 20'h00222;
	localparam logic [19:0] OFS_CTRL_FOURTH = 20'h00223;
	localparam logic [19:0] OFS_CTRL_GUARDED = 20'h00230;
	localparam logic [19:0] OFS_OPTION_FIRST = 20'h0ffff;
	localparam logic [7:0] REG_RESET = 8'h00;
	// primary control bits
	localparam int PRI_BUSY = 0;
	localparam int PRI_SUSP = 1;
	localparam int PRI_LOCK_DIS = 2;
	localparam int PRI_BLANK_FAIL = 4;
	localparam int PRI_OP_ERR = 5;
	localparam logic [7:0] PRI_RW_MASK = 8'h8c;
	// secondary control bits, then the option register protect bit
	localparam int SEC_GUARD_WE = 1;
	localparam int SEC_LOCK_STAT = 6;
	localparam logic [7:0] SEC_RW_MASK = 8'h02;
	localparam int READOUT_PROTECT_BIT = 0;
	// command codes, low byte only
	localparam logic [7:0] CMD_PROGRAM = 8'h41;
	localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
	localparam logic [7:0] CMD_LOCK_READ = 8'h71;
	localparam logic [7:0] CMD_BLANK = 8'h25;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'hd0;
	localparam logic [7:0] CMD_CLEAR = 8'h50;
	localparam int OP_CYCLES = 32;
	typedef enum logic [1:0] {MODE_CPU, MODE_SERIAL, MODE_PARALLEL}
		rewrite_mode_t;
	// host register offsets
	localparam logic [7:0] HOST_ADDR = 8'h00;
	localparam logic [7:0] HOST_DATA = 8'h04;
	localparam logic [7:0] HOST_CTRL = 8'h08;
	localparam logic [7:0] HOST_STATUS = 8'h0c;
	localparam logic [7:0] HOST_RDATA = 8'h10;
	localparam int CTRL_START = 0;
	localparam int CTRL_WE = 1;
	localparam int CTRL_REG = 2;
	localparam int CTRL_PROG32 = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_ALIGN_ERR = 1;
endpackage

// *** rtl/flash_cmd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface flash_cmd_if;
	logic req;
	logic we;
	logic reg_sel;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic ack;
	logic [15:0] rdata;
	modport device(input req, we, reg_sel, addr, wdata, output ack, rdata);
	modport host(output req, we, reg_sel, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

// *** rtl/flash_sequencer.sv ***
// Behaviour
// - program is code then two data writes
// - program address ends in 0, 4, 8, C
// - second write low half, third high
// - lock program: code then confirm sets lock
// - lock read reports block lock in flag
// - blank check: code then confirm at block
// - decode only low byte of command
// - block address is block's top even address
// - secondary bit 1 gates guarded register writes
// - secondary bit 6: 0 locked, 1 unlocked
// - primary bit 2 disables lock protection
// - erase and program can suspend and resume
// - protect bit 0 enables readout protection when clear
// - rewrite from cpu, serial or parallel
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module flash_sequencer #(
	parameter int BLOCKS = 4,
	parameter int BLK_WORDS = 16,
	parameter int OP_LEN = flash_seq_pkg::OP_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// processor side
	flash_cmd_if.device bus,
	// user side
	input wire logic [7:0] option_strap,
	input wire logic [1:0] rewrite_mode,
	output logic protect_active,
	output logic busy
);
	localparam int WORDS = BLOCKS * BLK_WORDS;
	localparam int IDX_W = $clog2(WORDS);
	localparam int BLK_W = $clog2(BLK_WORDS);
	generate
		if (WORDS < 2 || BLK_WORDS < 2 || OP_LEN < 2 || IDX_W + 2 > 20 ||
			(1 << IDX_W) != WORDS || (1 << BLK_W) != BLK_WORDS) begin : g_chk
			$error("flash_sequencer: unsupported geometry");
		end
	endgenerate

	typedef enum {ST_READ, ST_PROG_LO, ST_PROG_HI, ST_CONFIRM, ST_BUSY,
		ST_SUSP} state_t;
	typedef enum {OP_PROG, OP_ERASE, OP_LOCK, OP_BLANK, OP_LSTAT} op_t;

	logic [31:0] mem [WORDS];
	state_t state, next_state;
	op_t op, next_op;
	logic [19:0] tgt, next_tgt;
	logic [15:0] lo, next_lo, hi, next_hi, cnt, next_cnt;
	logic [BLOCKS-1:0] locked, next_locked;
	logic [7:0] pri, next_pri, sec, next_sec, third, next_third;
	logic [7:0] fourth, next_fourth, guarded, next_guarded, option;
	logic ack, next_ack, prog_we, erase_we, acc, wr, blocked;
	logic [15:0] rdata, next_rdata;
	logic [7:0] code, rreg;
	logic [9:0] pin_s1, pin_s2, pin_s3, pin_q, next_pin_q;

	// word index and block of a byte address
	function automatic logic [IDX_W-1:0] word_of(input logic [19:0] a);
		return a[IDX_W+1:2];
	endfunction
	function automatic logic [IDX_W-BLK_W-1:0] blk_of(input logic [19:0] a);
		return a[IDX_W+1:BLK_W+2];
	endfunction

	// blank means every word of the block still erased
	function automatic logic is_blank(input logic [IDX_W-BLK_W-1:0] b);
		logic r;
		r = 1'b1;
		for (int i = 0; i < BLK_WORDS; i++) begin
			if (mem[{b, BLK_W'(i)}] != 32'hffffffff)
				r = 1'b0;
		end
		return r;
	endfunction

	assign protect_active = ~option[flash_seq_pkg::READOUT_PROTECT_BIT];
	// external programmers are locked out while protected
	assign blocked = protect_active &&
		pin_q[9:8] != 2'(flash_seq_pkg::MODE_CPU);
	assign busy = state == ST_BUSY;
	assign acc = bus.req & ~ack;
	assign wr = acc & bus.we & ~bus.reg_sel & ~blocked;
	assign code = bus.wdata[7:0]; // upper byte ignored
	assign bus.ack = ack;
	assign bus.rdata = rdata;
	// pins pass three stages; levels are quasi-static, so the lag is harmless
	always_ff @(posedge clk) begin
		{pin_s3, pin_s2, pin_s1} <=
			{pin_s2, pin_s1, rewrite_mode, option_strap};
		pin_q <= next_pin_q;
	end

	// register read mux, live status bits overlaid
	always_comb begin
		rreg = 8'h00;
		case (bus.addr)
			flash_seq_pkg::OFS_CTRL_PRI: begin
				rreg = pri;
				rreg[flash_seq_pkg::PRI_BUSY] = busy;
				rreg[flash_seq_pkg::PRI_SUSP] = state == ST_SUSP;
			end
			flash_seq_pkg::OFS_CTRL_SEC: rreg = sec;
			flash_seq_pkg::OFS_CTRL_THIRD: rreg = third;
			flash_seq_pkg::OFS_CTRL_FOURTH: rreg = fourth;
			flash_seq_pkg::OFS_CTRL_GUARDED: rreg = guarded;
			flash_seq_pkg::OFS_OPTION_FIRST: rreg = option;
			default: rreg = 8'h00;
		endcase
	end

	// command sequencer and register file next state
	always_comb begin
		next_state = state;
		next_op = op;
		next_tgt = tgt;
		next_lo = lo;
		next_hi = hi;
		next_cnt = cnt;
		next_locked = locked;
		next_pri = pri;
		next_sec = sec;
		next_third = third;
		next_fourth = fourth;
		next_guarded = guarded;
		prog_we = 1'b0;
		erase_we = 1'b0;
		next_ack = acc;
		next_rdata = rdata;
		next_pin_q = pin_s2 == pin_s3 ? pin_s3 : pin_q; // stages agree
		if (acc && bus.reg_sel && bus.we) begin
			case (bus.addr)
				flash_seq_pkg::OFS_CTRL_PRI: next_pri =
					(pri & ~flash_seq_pkg::PRI_RW_MASK) |
					(bus.wdata[7:0] & flash_seq_pkg::PRI_RW_MASK);
				flash_seq_pkg::OFS_CTRL_SEC: next_sec =
					(sec & ~flash_seq_pkg::SEC_RW_MASK) |
					(bus.wdata[7:0] & flash_seq_pkg::SEC_RW_MASK);
				flash_seq_pkg::OFS_CTRL_THIRD: next_third = bus.wdata[7:0];
				flash_seq_pkg::OFS_CTRL_FOURTH: next_fourth = bus.wdata[7:0];
				flash_seq_pkg::OFS_CTRL_GUARDED:
					if (sec[flash_seq_pkg::SEC_GUARD_WE])
						next_guarded = bus.wdata[7:0];
				default: ;
			endcase
		end
		if (acc && !bus.we) begin
			if (bus.reg_sel)
				next_rdata = {8'h00, rreg};
			else if (blocked)
				next_rdata = 16'h0000;
			else if (bus.addr[1])
				next_rdata = mem[word_of(bus.addr)][31:16];
			else
				next_rdata = mem[word_of(bus.addr)][15:0];
		end
		case (state)
			ST_READ: if (wr) begin
				next_tgt = bus.addr;
				next_state = ST_CONFIRM;
				case (code)
					flash_seq_pkg::CMD_PROGRAM: next_state = ST_PROG_LO;
					flash_seq_pkg::CMD_ERASE: next_op = OP_ERASE;
					flash_seq_pkg::CMD_LOCK_PROG: next_op = OP_LOCK;
					flash_seq_pkg::CMD_LOCK_READ: next_op = OP_LSTAT;
					flash_seq_pkg::CMD_BLANK: next_op = OP_BLANK;
					flash_seq_pkg::CMD_CLEAR: begin
						next_pri[flash_seq_pkg::PRI_OP_ERR] = 1'b0;
						next_pri[flash_seq_pkg::PRI_BLANK_FAIL] = 1'b0;
						next_state = ST_READ;
					end
					default: next_state = ST_READ;
				endcase
			end
			ST_PROG_LO: if (wr) begin
				next_lo = bus.wdata; // second cycle is low half
				next_state = ST_PROG_HI;
			end
			ST_PROG_HI: if (wr) begin
				next_hi = bus.wdata; // third cycle is high half
				next_op = OP_PROG;
				next_cnt = 16'(OP_LEN);
				next_state = ST_BUSY;
				// lock bits honoured only while not disabled
				if (locked[blk_of(tgt)] && !pri[flash_seq_pkg::PRI_LOCK_DIS]) begin
					next_pri[flash_seq_pkg::PRI_OP_ERR] = 1'b1;
					next_state = ST_READ;
				end
			end
			ST_CONFIRM: if (wr) begin
				next_state = ST_READ;
				if (code == flash_seq_pkg::CMD_CONFIRM) begin
					next_tgt = bus.addr; // block address
					next_cnt = 16'(OP_LEN);
					if (op == OP_LSTAT)
						next_sec[flash_seq_pkg::SEC_LOCK_STAT] =
							~locked[blk_of(bus.addr)];
					else if (op == OP_ERASE && locked[blk_of(bus.addr)] &&
						!pri[flash_seq_pkg::PRI_LOCK_DIS])
						next_pri[flash_seq_pkg::PRI_OP_ERR] = 1'b1;
					else
						next_state = ST_BUSY;
				end
			end
			ST_BUSY: begin
				// only suspend is heard while busy
				if (wr && code == flash_seq_pkg::CMD_SUSPEND &&
					(op == OP_PROG || op == OP_ERASE)) begin
					next_state = ST_SUSP;
				end else if (cnt == 16'h0001) begin
					next_state = ST_READ;
					case (op)
						OP_PROG: prog_we = 1'b1; // both halves at once
						OP_ERASE: erase_we = 1'b1;
						OP_LOCK: next_locked[blk_of(tgt)] = 1'b1;
						OP_BLANK: next_pri[flash_seq_pkg::PRI_BLANK_FAIL] =
							~is_blank(blk_of(tgt));
						default: ;
					endcase
				end else begin
					next_cnt = cnt - 16'h0001;
				end
			end
			ST_SUSP: if (wr && code == flash_seq_pkg::CMD_RESUME)
				next_state = ST_BUSY; // counter kept, work resumes
			default: next_state = ST_READ;
		endcase
	end

	// state and memory registers
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_READ;
			op <= OP_PROG;
			tgt <= 20'h00000;
			lo <= 16'h0000;
			hi <= 16'h0000;
			cnt <= 16'h0000;
			locked <= '0;
			pri <= flash_seq_pkg::REG_RESET;
			sec <= flash_seq_pkg::REG_RESET;
			third <= flash_seq_pkg::REG_RESET;
			fourth <= flash_seq_pkg::REG_RESET;
			guarded <= flash_seq_pkg::REG_RESET;
			option <= next_pin_q[7:0]; // strap caught while reset held
			ack <= 1'b0;
			rdata <= 16'h0000;
		end else begin
			state <= next_state;
			op <= next_op;
			tgt <= next_tgt;
			lo <= next_lo;
			hi <= next_hi;
			cnt <= next_cnt;
			locked <= next_locked;
			pri <= next_pri;
			sec <= next_sec;
			third <= next_third;
			fourth <= next_fourth;
			guarded <= next_guarded;
			ack <= next_ack;
			rdata <= next_rdata;
		end
		if (prog_we)
			mem[word_of(tgt)] <= {hi, lo};
		if (erase_we) begin
			for (int i = 0; i < BLK_WORDS; i++)
				mem[{blk_of(tgt), BLK_W'(i)}] <= 32'hffffffff;
		end
	end
endmodule
`default_nettype wire

// *** rtl/cpu_rewrite_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_rewrite_host (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// flash command link
	flash_cmd_if.host bus
);
	typedef enum {H_IDLE, H_REQ} hstate_t;
	hstate_t state, next_state;
	logic [19:0] addr, next_addr;
	logic [31:0] data, next_data;
	logic [15:0] rdata, next_rdata;
	logic we, next_we, rsel, next_rsel, p32, next_p32, err, next_err;
	logic [1:0] step, next_step;
	logic [15:0] wd, next_wd;
	logic ack, next_ack;
	logic [31:0] dout, next_dout;
	logic wbw;
	logic [31:0] addr_merged;

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction

	assign wbw = wb_cyc_i & wb_stb_i & wb_we_i & ~ack;
	assign addr_merged = merge({12'h000, addr}, wb_dat_i, wb_sel_i);
	assign wb_ack_o = ack;
	assign wb_dat_o = dout;
	assign bus.req = state == H_REQ;
	assign bus.we = we;
	assign bus.reg_sel = rsel;
	assign bus.addr = addr;
	assign bus.wdata = wd;

	// wishbone registers and link sequencing
	always_comb begin
		next_state = state;
		next_addr = addr;
		next_data = data;
		next_rdata = rdata;
		next_we = we;
		next_rsel = rsel;
		next_p32 = p32;
		next_err = err;
		next_step = step;
		next_wd = wd;
		next_ack = wb_cyc_i & wb_stb_i & ~ack;
		next_dout = dout;
		if (wb_cyc_i && wb_stb_i && !ack && !wb_we_i) begin
			case (wb_adr_i)
				flash_seq_pkg::HOST_ADDR: next_dout = {12'h000, addr};
				flash_seq_pkg::HOST_DATA: next_dout = data;
				flash_seq_pkg::HOST_STATUS: next_dout = {30'h0, err,
					state == H_REQ};
				flash_seq_pkg::HOST_RDATA: next_dout = {16'h0000, rdata};
				default: next_dout = 32'h00000000;
			endcase
		end
		if (wbw && state == H_IDLE) begin
			case (wb_adr_i)
				flash_seq_pkg::HOST_ADDR: next_addr =
					addr_merged[19:0];
				flash_seq_pkg::HOST_DATA: next_data =
					merge(data, wb_dat_i, wb_sel_i);
				flash_seq_pkg::HOST_CTRL: if (wb_sel_i[0]) begin
					next_we = wb_dat_i[flash_seq_pkg::CTRL_WE];
					next_rsel = wb_dat_i[flash_seq_pkg::CTRL_REG];
					next_p32 = wb_dat_i[flash_seq_pkg::CTRL_PROG32];
					next_step = 2'd0;
					next_wd = data[15:0];
					if (wb_dat_i[flash_seq_pkg::CTRL_PROG32]) begin
						next_we = 1'b1;
						next_rsel = 1'b0;
						next_wd = {8'h00, flash_seq_pkg::CMD_PROGRAM};
						// unaligned units are refused here
						if (addr[1:0] != 2'b00)
							next_err = 1'b1;
						else
							next_state = H_REQ;
					end else if (wb_dat_i[flash_seq_pkg::CTRL_START]) begin
						next_state = H_REQ; // block address from software
					end
				end
				default: ;
			endcase
		end
		if (bus.ack) begin
			// same address throughout, low half before high
			if (p32 && step == 2'd0) begin
				next_step = 2'd1;
				next_wd = data[15:0];
			end else if (p32 && step == 2'd1) begin
				next_step = 2'd2;
				next_wd = data[31:16];
			end else begin
				next_state = H_IDLE;
				if (!we)
					next_rdata = bus.rdata;
			end
		end
		// sticky error clears on write of one; a new error wins
		if (wbw && wb_adr_i == flash_seq_pkg::HOST_STATUS && wb_sel_i[0] &&
			wb_dat_i[flash_seq_pkg::STAT_ALIGN_ERR] && next_err == err)
			next_err = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= H_IDLE;
			addr <= 20'h00000;
			data <= 32'h00000000;
			rdata <= 16'h0000;
			we <= 1'b0;
			rsel <= 1'b0;
			p32 <= 1'b0;
			err <= 1'b0;
			step <= 2'd0;
			wd <= 16'h0000;
			ack <= 1'b0;
			dout <= 32'h00000000;
		end else begin
			state <= next_state;
			addr <= next_addr;
			data <= next_data;
			rdata <= next_rdata;
			we <= next_we;
			rsel <= next_rsel;
			p32 <= next_p32;
			err <= next_err;
			step <= next_step;
			wd <= next_wd;
			ack <= next_ack;
			dout <= next_dout;
		end
	end
endmodule
`default_nettype wire

// *** tb/flash_rewrite_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_rewrite_asserts #(
	parameter int OP_LEN = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// link signals
	input wire logic req,
	input wire logic we,
	input wire logic reg_sel,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic [15:0] rdata,
	// sequencer pins
	input wire logic [1:0] rewrite_mode,
	input wire logic busy,
	input wire logic protect_active
);
	int busy_cnt;
	int next_busy_cnt;
	logic cmd_take;
	logic locked_out;
	// length of the current busy stretch; a suspend restarts the count
	always_comb begin
		next_busy_cnt = busy ? busy_cnt + 1 : 0;
	end
	always_ff @(posedge clk) begin
		busy_cnt <= reset ? 0 : next_busy_cnt;
	end
	// flash command write taken this cycle
	assign cmd_take = req && !ack && we && !reg_sel;
	assign locked_out = protect_active && rewrite_mode != 2'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_ack_one; req && !ack |=> ack; endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("no ack one cycle after request");
	property p_ack_pulse; ack |=> !ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_ack_idle; !req |=> !ack; endproperty
	a_ack_idle: assert property (p_ack_idle)
		else $error("ack without request");
	property p_busy_len; busy_cnt <= OP_LEN; endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy outlasts operation length");
	property p_busy_cause; $rose(busy) |-> ack || $past(ack); endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy rose without command write");
	property p_suspend;
		busy && cmd_take && wdata[7:0] == flash_seq_pkg::CMD_SUSPEND
			|-> ##[1:2] !busy;
	endproperty
	a_suspend: assert property (p_suspend)
		else $error("suspend did not stop busy");
	property p_prot_hold; $stable(protect_active); endproperty
	a_prot_hold: assert property (p_prot_hold)
		else $error("protect changed outside reset");
	property p_prot_read;
		locked_out && req && !ack && !we && !reg_sel |=> rdata == 16'h0000;
	endproperty
	a_prot_read: assert property (p_prot_read)
		else $error("protected read returned data");
	property p_prot_cmd; locked_out && !busy && cmd_take |=> !busy; endproperty
	a_prot_cmd: assert property (p_prot_cmd)
		else $error("protected command started work");
	property p_rdata_hold; $changed(rdata) |-> ack; endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without ack");
	// main scenarios reached
	c_program: cover property (cmd_take && wdata[7:0] == 8'h41);
	c_suspend: cover property (busy && cmd_take && wdata[7:0] == 8'hb0);
	c_done: cover property ($fell(busy));
endmodule
`default_nettype wire

// *** tb/test_flash_rewrite_command_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
	error_cnt++; $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module test_flash_rewrite_command_sequencer;
	localparam int OPL = 40;
	logic clk, reset, busy, prot, cyc, stb, wwe, ack;
	logic [1:0] mode;
	logic [7:0] strap, adr;
	logic [3:0] sel;
	logic [31:0] dat, dout;
	logic [15:0] q;
	logic [31:0] rd;
	int error_cnt, samples_checked;
	flash_cmd_if link();
	flash_sequencer #(.OP_LEN(OPL)) flash_sequencer_inst (.clk(clk),
		.reset(reset), .bus(link), .option_strap(strap),
		.rewrite_mode(mode), .protect_active(prot), .busy(busy));
	cpu_rewrite_host cpu_rewrite_host_inst (.clk(clk), .reset(reset),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
		.bus(link));
	flash_rewrite_asserts #(.OP_LEN(OPL)) flash_rewrite_asserts_inst (
		.clk(clk), .reset(reset), .req(link.req), .we(link.we),
		.reg_sel(link.reg_sel), .wdata(link.wdata), .ack(link.ack),
		.rdata(link.rdata), .rewrite_mode(mode), .busy(busy),
		.protect_active(prot));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// one classic wishbone cycle; waits for ack, never assumes latency
	task automatic wbx(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		cyc <= 1'b1; stb <= 1'b1; wwe <= w; adr <= a; dat <= d;
		@(posedge clk);
		for (int i = 0; i < 100 && ack !== 1'b1; i++) @(posedge clk);
		if (ack !== 1'b1)
			error_cnt++;
		r = dout;
		cyc <= 1'b0; stb <= 1'b0;
		@(posedge clk);
	endtask
	// poll host status until its link work is over; a stuck host counts
	task automatic wait_host(output logic [31:0] r);
		r = 32'h1;
		for (int i = 0; i < 20 && r[0] !== 1'b0; i++)
			wbx(1'b0, flash_seq_pkg::HOST_STATUS, 32'h0, r);
		if (r[0] !== 1'b0)
			error_cnt++;
	endtask
	// one link transfer through the host; status polled until idle
	task automatic xfer(input logic rs, input logic w, input logic [19:0] a,
		input logic [15:0] d);
		logic [31:0] r;
		wbx(1'b1, flash_seq_pkg::HOST_ADDR, {12'h000, a}, r);
		wbx(1'b1, flash_seq_pkg::HOST_DATA, {16'h0000, d}, r);
		wbx(1'b1, flash_seq_pkg::HOST_CTRL, {29'h0, rs, w, 1'b1}, r);
		wait_host(r);
		wbx(1'b0, flash_seq_pkg::HOST_RDATA, 32'h0, r);
		q = r[15:0];
	endtask
	task automatic cmd(input logic [19:0] a, input logic [15:0] d);
		xfer(1'b0, 1'b1, a, d);
	endtask
	task automatic idle();
		for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
		if (busy !== 1'b0)
			error_cnt++;
	endtask
	// two-write command then wait for the operation to end
	task automatic op2(input logic [19:0] a, input logic [15:0] c,
		input logic [19:0] b);
		cmd(a, c);
		cmd(b, 16'h00d0);
		idle();
	endtask
	task automatic prog(input logic [19:0] a, input logic [31:0] d);
		cmd(a, 16'hff41); // upper byte ignored
		cmd(a, d[15:0]);
		cmd(a, d[31:16]);
		idle();
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, far beyond the expected run
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
	// main sequence
	initial begin
		error_cnt = 0; samples_checked = 0;
		reset = 1'b1; strap = 8'h00; mode = 2'h0; cyc = 1'b0; stb = 1'b0;
		wwe = 1'b0; adr = 8'h00; sel = 4'hf; dat = 32'h0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK("protect", 1'b1, prot)
		cmd(20'h00000, 16'h0020);
		cmd(20'h0003e, 16'h00d0);
		`CHK("busy erase", 1'b1, busy)
		cmd(20'h00000, 16'hffb0);
		`CHK("busy suspended", 1'b0, busy)
		xfer(1'b1, 1'b0, flash_seq_pkg::OFS_CTRL_PRI, 16'h0);
		`CHK("suspend flag", 1'b1, q[1])
		cmd(20'h00000, 16'h00d0);
		`CHK("busy resumed", 1'b1, busy)
		idle();
		prog(20'h00010, 32'h1234_5678);
		xfer(1'b0, 1'b0, 20'h00010, 16'h0);
		`CHK("low half", 16'h5678, q)
		xfer(1'b0, 1'b0, 20'h00012, 16'h0);
		`CHK("high half", 16'h1234, q)
		op2(20'h00008, 16'hff25, 20'h0003e);
		xfer(1'b1, 1'b0, flash_seq_pkg::OFS_CTRL_PRI, 16'h0);
		`CHK("blank fail", 1'b1, q[4])
		op2(20'h00040, 16'h0020, 20'h0007e);
		cmd(20'h00000, 16'h0050);
		op2(20'h00040, 16'h0025, 20'h0007e);
		xfer(1'b1, 1'b0, flash_seq_pkg::OFS_CTRL_PRI, 16'h0);
		`CHK("blank pass", 1'b0, q[4])
		op2(20'h0003e, 16'h0077, 20'h0003e);
		op2(20'h00044, 16'h0071, 20'h0003e);
		xfer(1'b1, 1'b0, flash_seq_pkg::OFS_CTRL_SEC, 16'h0);
		`CHK("locked", 1'b0, q[6])
		op2(20'h00004, 16'h0071, 20'h0007e);
		xfer(1'b1, 1'b0, flash_seq_pkg::OFS_CTRL_SEC, 16'h0);
		`CHK("unlocked", 1'b1, q[6])
		prog(20'h00020, 32'h5555_aaaa);
		xfer(1'b0, 1'b0, 20'h00020, 16'h0);
		`CHK("lock held", 16'hffff, q)
		xfer(1'b1, 1'b1, flash_seq_pkg::OFS_CTRL_PRI, 16'h0004);
		prog(20'h00024, 32'h5555_aaaa);
		xfer(1'b0, 1'b0, 20'h00024, 16'h0);
		`CHK("lock off", 16'haaaa, q)
		// host-sequenced unit: unaligned refused, aligned one written
		wbx(1'b1, flash_seq_pkg::HOST_DATA, 32'h9abc_def0, rd);
		wbx(1'b1, flash_seq_pkg::HOST_ADDR, 32'h0000_004a, rd);
		wbx(1'b1, flash_seq_pkg::HOST_CTRL, 32'h0000_0008, rd);
		wait_host(rd);
		`CHK("align error", 1'b1, rd[1])
		wbx(1'b1, flash_seq_pkg::HOST_STATUS, 32'h0000_0002, rd);
		wbx(1'b1, flash_seq_pkg::HOST_ADDR, 32'h0000_0048, rd);
		wbx(1'b1, flash_seq_pkg::HOST_CTRL, 32'h0000_0008, rd);
		wait_host(rd);
		`CHK("align clear", 1'b0, rd[1])
		idle();
		xfer(1'b0, 1'b0, 20'h00048, 16'h0);
		`CHK("unit low", 16'hdef0, q)
		xfer(1'b0, 1'b0, 20'h0004a, 16'h0);
		`CHK("unit high", 16'h9abc, q)
		// program suspended mid-operation, then resumed
		cmd(20'h00050, 16'h0041);
		cmd(20'h00050, 16'h4321);
		cmd(20'h00050, 16'h8765);
		cmd(20'h00050, 16'h00b0);
		`CHK("program suspended", 1'b0, busy)
		cmd(20'h00050, 16'h00d0);
		`CHK("program resumed", 1'b1, busy)
		idle();
		xfer(1'b0, 1'b0, 20'h00052, 16'h0);
		`CHK("program after resume", 16'h8765, q)
		xfer(1'b1, 1'b1, flash_seq_pkg::OFS_CTRL_GUARDED, 16'h005a);
		xfer(1'b1, 1'b0, flash_seq_pkg::OFS_CTRL_GUARDED, 16'h0);
		`CHK("guard shut", 8'h00, q[7:0])
		xfer(1'b1, 1'b1, flash_seq_pkg::OFS_CTRL_SEC, 16'h0002);
		xfer(1'b1, 1'b1, flash_seq_pkg::OFS_CTRL_GUARDED, 16'h005a);
		xfer(1'b1, 1'b0, flash_seq_pkg::OFS_CTRL_GUARDED, 16'h0);
		`CHK("guard open", 8'h5a, q[7:0])
		for (int m = 1; m < 3; m++) begin
			mode <= m[1:0];
			xfer(1'b0, 1'b0, 20'h00010, 16'h0);
			`CHK("protected read", 16'h0000, q)
			cmd(20'h00000, 16'h0020);
			cmd(20'h0003e, 16'h00d0);
			`CHK("protected erase", 1'b0, busy)
		end
		reset <= 1'b1;
		strap <= 8'h01;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		`CHK("unprotected", 1'b0, prot)
		xfer(1'b0, 1'b0, 20'h00010, 16'h0);
		`CHK("parallel read", 16'h5678, q)
		complete_run();
	end
endmodule
`default_nettype wire
